// ==== hdl/dtc_top.sv ====
/*
 * Debug trigger control: control register, arm and run tracking,
 * comparator direction qualification and break request generation.
 * Assumes raw comparator matches, FIFO full and bus cycle signals come
 * from logic on mclk; the secure level arrives from a pin.
 */
`timescale 1ns/1ps
module dtc_top (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Security pin
    input  wire logic        secure_pin,
    // CPU bus cycle and comparator raw matches
    input  wire logic        bus_valid,
    input  wire logic        bus_read,
    input  wire logic        comp_a_hit,
    input  wire logic        comp_b_addr_hit,
    input  wire logic        comp_b_rdata_hit,
    input  wire logic        comp_b_wdata_hit,
    input  wire logic        serial_debug_port_busy,
    // Capture FIFO
    input  wire logic        fifo_full,
    output logic             capture_enable,
    output logic             run_stop,
    // Comparator setup towards match logic
    output logic             comp_b_data_mode,
    output logic             comp_b_use_wdata,
    output logic             trigger_select_option,
    // Break request to CPU core
    output logic             break_req,
    output logic             break_tag,
    output logic             trigger_hit
);

    logic [7:0]  debug_control_r;
    logic [2:0]  config_r;
    logic        capture_active_flag_r;
    dtc_pkg::dtc_run_type run_state_r;
    logic        ack_r;
    logic        secure_s;
    logic        fifo_full_d_r;
    logic        qual_a;
    logic        qual_b;
    logic        comp_b_raw;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        wr_arm_set;
    logic        wr_stop;
    logic        armed_en;
    logic        trigger;
    logic        fifo_fill;
    logic        run_complete;
    logic        brk_cause;
    logic [31:0] rd_mux;

    // Field helper used for the written control value
    function automatic logic ctl_bit(input logic [7:0] v, input int pos);
        ctl_bit = v[pos];
    endfunction

    // Secure level comes from a pin, so it is synchronised first
    dtc_sync #(
        .WIDTH(1)
    ) u_secure_sync (
        .mclk    (mclk),
        .resetn  (resetn),
        .ce      (ce),
        .async_in(secure_pin),
        .sync_out(secure_s)
    );

    // Bus handshake: every access waits exactly one cycle
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // A write lands on the edge where waitrequest is low; no arm or mode gate
    assign wr_ctrl = avs_write && ack_r && (avs_address == dtc_pkg::OFF_CONTROL)
                     && avs_byteenable[dtc_pkg::LANE_LOW];
    assign wr_cfg  = avs_write && ack_r && (avs_address == dtc_pkg::OFF_CONFIG)
                     && avs_byteenable[dtc_pkg::LANE_LOW];

    assign wr_arm_set = wr_ctrl && ctl_bit(avs_writedata[7:0], dtc_pkg::BIT_ARM);
    // Clearing arm or enable is a stop write; the run phase and active flag reset only when arm is written 0
    assign wr_stop    = wr_ctrl && (!ctl_bit(avs_writedata[7:0], dtc_pkg::BIT_ARM)
                        || !ctl_bit(avs_writedata[7:0], dtc_pkg::BIT_ENABLE));

    // Module is live only when enabled and armed
    assign armed_en = debug_control_r[dtc_pkg::BIT_ENABLE] && debug_control_r[dtc_pkg::BIT_ARM];

    // Comparator A always watches the address bus
    dtc_qual u_qual_a (
        .raw_match  (comp_a_hit),
        .bus_valid  (bus_valid),
        .bus_read   (bus_read),
        .dir_qualify(debug_control_r[dtc_pkg::BIT_A_QUALIFY]),
        .dir_value  (debug_control_r[dtc_pkg::BIT_A_VALUE]),
        .blank      (serial_debug_port_busy),
        .qual_match (qual_a)
    );

    // Comparator B source: address, or the data bus picked by the A direction bits
    assign comp_b_use_wdata = config_r[dtc_pkg::CFG_DATA_MODE]
                              && debug_control_r[dtc_pkg::BIT_A_QUALIFY]
                              && !debug_control_r[dtc_pkg::BIT_A_VALUE];
    assign comp_b_data_mode = config_r[dtc_pkg::CFG_DATA_MODE];
    assign comp_b_raw = !config_r[dtc_pkg::CFG_DATA_MODE] ? comp_b_addr_hit
                        : (comp_b_use_wdata ? comp_b_wdata_hit : comp_b_rdata_hit);

    dtc_qual u_qual_b (
        .raw_match  (comp_b_raw),
        .bus_valid  (bus_valid),
        .bus_read   (bus_read),
        .dir_qualify(debug_control_r[dtc_pkg::BIT_B_QUALIFY]),
        .dir_value  (debug_control_r[dtc_pkg::BIT_B_VALUE]),
        .blank      (serial_debug_port_busy),
        .qual_match (qual_b)
    );

    assign trigger_select_option = config_r[dtc_pkg::CFG_TRIG_SELECT];

    // Trigger, FIFO fill edge and run completion
    assign trigger   = armed_en && (qual_a || qual_b);
    assign fifo_fill = armed_en && fifo_full && !fifo_full_d_r;
    // Trigger select is deliberately absent: only trace type sets the moment
    assign run_complete = config_r[dtc_pkg::CFG_BEGIN_TRACE] ? fifo_fill : trigger;
    assign brk_cause = debug_control_r[dtc_pkg::BIT_BREAK_REQUEST_ENABLE]
                       && (config_r[dtc_pkg::CFG_BEGIN_TRACE] ? fifo_fill
                                                              : trigger);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fifo_full_d_r <= 1'b0;
        end else if (ce) begin
            fifo_full_d_r <= fifo_full;
        end
    end

    // Control register; arm set by software wins over a same-cycle completion
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            debug_control_r <= dtc_pkg::CTL_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                debug_control_r[5:0] <= avs_writedata[5:0];
                debug_control_r[dtc_pkg::BIT_ARM] <= ctl_bit(avs_writedata[7:0], dtc_pkg::BIT_ARM);
                // Enable cannot be raised while secure
                debug_control_r[dtc_pkg::BIT_ENABLE] <= ctl_bit(avs_writedata[7:0], dtc_pkg::BIT_ENABLE)
                                                        && !(secure_s && !debug_control_r[dtc_pkg::BIT_ENABLE]);
            end else if (run_complete) begin
                debug_control_r[dtc_pkg::BIT_ARM] <= 1'b0;
            end
        end
    end

    // Active flag follows arm writes and run ends
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            capture_active_flag_r <= 1'b0;
        end else if (ce) begin
            if (wr_arm_set) begin
                capture_active_flag_r <= 1'b1;
            end else if (wr_stop || run_complete) begin
                capture_active_flag_r <= 1'b0;
            end
        end
    end

    // Run phase for status readback
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_state_r <= dtc_pkg::RUN_IDLE;
        end else if (ce) begin
            case (run_state_r)
                dtc_pkg::RUN_IDLE: begin
                    if (wr_arm_set) begin
                        run_state_r <= dtc_pkg::RUN_ACTIVE;
                    end
                end
                dtc_pkg::RUN_ACTIVE: begin
                    if (wr_arm_set) begin
                        run_state_r <= dtc_pkg::RUN_ACTIVE;
                    end else if (wr_stop) begin
                        run_state_r <= dtc_pkg::RUN_IDLE;
                    end else if (run_complete) begin
                        run_state_r <= dtc_pkg::RUN_DONE;
                    end
                end
                dtc_pkg::RUN_DONE: begin
                    if (wr_arm_set) begin
                        run_state_r <= dtc_pkg::RUN_ACTIVE;
                    end
                end
                default: begin
                    run_state_r <= dtc_pkg::RUN_IDLE;
                end
            endcase
        end
    end

    // Configuration register of trace type, trigger select and data mode
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            config_r <= dtc_pkg::CFG_RESET;
        end else if (ce && wr_cfg) begin
            config_r <= avs_writedata[2:0];
        end
    end

    // Break pulse carries the kind selected at the cause
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            break_req   <= 1'b0;
            break_tag   <= 1'b0;
            trigger_hit <= 1'b0;
            run_stop    <= 1'b0;
        end else if (ce) begin
            break_req   <= brk_cause;
            break_tag   <= brk_cause && debug_control_r[dtc_pkg::BIT_TAG];
            trigger_hit <= trigger;
            run_stop    <= wr_stop && armed_en;
        end
    end

    // FIFO stores only while live; a stop write cuts it the next edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            capture_enable <= 1'b0;
        end else if (ce) begin
            capture_enable <= wr_ctrl ? (ctl_bit(avs_writedata[7:0], dtc_pkg::BIT_ARM)
                                         && ctl_bit(avs_writedata[7:0], dtc_pkg::BIT_ENABLE)
                                         && !(secure_s && !debug_control_r[dtc_pkg::BIT_ENABLE]))
                                      : (armed_en && !run_complete);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            dtc_pkg::OFF_CONTROL: rd_mux[7:0] = debug_control_r;
            dtc_pkg::OFF_STATUS: begin
                rd_mux[dtc_pkg::STS_ACTIVE_FLAG] = capture_active_flag_r;
                rd_mux[dtc_pkg::STS_RUNNING]     = (run_state_r == dtc_pkg::RUN_ACTIVE);
                rd_mux[dtc_pkg::STS_DONE]        = (run_state_r == dtc_pkg::RUN_DONE);
                rd_mux[dtc_pkg::STS_SECURE]      = secure_s;
            end
            dtc_pkg::OFF_CONFIG: rd_mux[2:0] = config_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured at the first edge, stable through the answering edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && avs_read && !ack_r) begin
            avs_readdata <= rd_mux;
        end
    end

    a_low_bits_land: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_ctrl) |=> (debug_control_r[5:0] == $past(avs_writedata[5:0])))
        else $error("Control write did not land");

    a_secure_block: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_ctrl && secure_s && !debug_control_r[dtc_pkg::BIT_ENABLE])
        |=> !debug_control_r[dtc_pkg::BIT_ENABLE])
        else $error("Enable set while secure");

    a_arm_flag_set: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_arm_set) |=> (capture_active_flag_r && debug_control_r[dtc_pkg::BIT_ARM]))
        else $error("Arm write did not set active flag");

    a_run_clears_arm: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && run_complete && !wr_ctrl) |=> !debug_control_r[dtc_pkg::BIT_ARM])
        else $error("Arm not cleared at run end");

    a_stop_write: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wr_stop) |=> (!capture_enable && !armed_en))
        else $error("Run not stopped by write");

    a_break_kind: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && brk_cause) |=> (break_req && break_tag == $past(debug_control_r[dtc_pkg::BIT_TAG])))
        else $error("Break kind wrong");

    a_break_off: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && !debug_control_r[dtc_pkg::BIT_BREAK_REQUEST_ENABLE]) |=> !break_req)
        else $error("Break with breaks disabled");

    a_end_timing: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && debug_control_r[dtc_pkg::BIT_BREAK_REQUEST_ENABLE] && !config_r[dtc_pkg::CFG_BEGIN_TRACE] && trigger)
        |=> break_req)
        else $error("End trace break missing");

    a_begin_timing: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && config_r[dtc_pkg::CFG_BEGIN_TRACE] && !fifo_fill) |=> !break_req)
        else $error("Begin trace break without FIFO fill");

    a_dir_qual_a: assert property (@(posedge mclk) disable iff (!resetn)
        (debug_control_r[dtc_pkg::BIT_A_QUALIFY] && bus_read != debug_control_r[dtc_pkg::BIT_A_VALUE])
        |-> !qual_a)
        else $error("Comparator A direction ignored");

    a_port_blank: assert property (@(posedge mclk) disable iff (!resetn)
        serial_debug_port_busy |-> !(qual_a || qual_b))
        else $error("Comparator active during port access");

    a_pulse_single: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && break_req) |=> !break_req)
        else $error("Break longer than one cycle");

endmodule

// ==== inc/dtc_pkg.sv ====
/*
 * Constants shared by the debug trigger control block: register offsets,
 * control field positions, reset values and the run state type.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package dtc_pkg;

    // Register byte offsets
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_CONFIG  = 4'h8;

    // Control register fields
    localparam int CTL_WIDTH      = 8;
    localparam int BIT_ENABLE     = 7;
    localparam int BIT_ARM        = 6;
    localparam int BIT_TAG        = 5;
    localparam int BIT_BREAK_REQUEST_ENABLE      = 4;
    localparam int BIT_A_VALUE    = 3;
    localparam int BIT_A_QUALIFY  = 2;
    localparam int BIT_B_VALUE    = 1;
    localparam int BIT_B_QUALIFY  = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Status register fields
    localparam int STS_ACTIVE_FLAG = 0;
    localparam int STS_RUNNING     = 1;
    localparam int STS_DONE        = 2;
    localparam int STS_SECURE      = 3;

    // Configuration register fields
    localparam int CFG_WIDTH       = 3;
    localparam int CFG_BEGIN_TRACE = 0;
    localparam int CFG_TRIG_SELECT = 1;
    localparam int CFG_DATA_MODE   = 2;
    localparam logic [2:0] CFG_RESET = 3'h0;

    // Avalon lane holding the low byte
    localparam int LANE_LOW = 0;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_ACTIVE,
        RUN_DONE
    } dtc_run_type;

endpackage

// ==== hdl/dtc_sync.sv ====
/*
 * Two-stage level synchroniser for pins from outside the mclk domain.
 * Assumes the input is a slow level; pulses shorter than one clock may be lost.
 */
`timescale 1ns/1ps
module dtc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_r;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage1_r <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end

endmodule

// ==== hdl/dtc_qual.sv ====
/*
 * Direction qualifier for one comparator: gates a raw match with the
 * read/write level of the current CPU bus cycle.
 * Assumes raw_match and bus signals come from the mclk domain.
 */
`timescale 1ns/1ps
module dtc_qual (
    input  wire logic raw_match,
    input  wire logic bus_valid,
    input  wire logic bus_read,
    input  wire logic dir_qualify,
    input  wire logic dir_value,
    input  wire logic blank,
    output logic      qual_match
);

    logic dir_ok;

    // Value 0 selects write cycles, 1 selects read cycles
    assign dir_ok     = !dir_qualify || (bus_read == dir_value);
    // Comparators are blind while the serial port owns the bus
    assign qual_match = raw_match && bus_valid && dir_ok && !blank;

endmodule

// ==== test/dtc_cpu_model.sv ====
/*
 * Behavioural CPU core on the receiving end of break requests.
 * Assumes break_req and break_tag are registered outputs on mclk.
 */
`timescale 1ns/1ps
module dtc_cpu_model (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic break_req,
    input  wire logic break_tag,
    output int        n_force,
    output int        n_tag,
    output int        n_long
);
    logic held_r;

    // Tally breaks by kind; a request still high a cycle later is a stretched pulse
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            held_r  <= 1'b0;
            n_force <= 0;
            n_tag   <= 0;
            n_long  <= 0;
        end else begin
            held_r <= break_req;
            if (break_req === 1'b1 && break_tag === 1'b1) n_tag <= n_tag + 1;
            if (break_req === 1'b1 && break_tag === 1'b0) n_force <= n_force + 1;
            if (break_req === 1'b1 && held_r === 1'b1) n_long <= n_long + 1;
        end
    end
endmodule

// ==== test/dtc_top_test.sv ====
/*
 * Self-checking bench for the debug trigger control block.
 * Assumes one mclk domain at 40 MHz and the CPU model beside the design.
 */
`timescale 1ns/1ps
module dtc_top_test;
    logic        mclk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        secure_pin, bus_valid, bus_read, comp_a_hit, comp_b_addr_hit, serial_debug_port_busy, fifo_full;
    logic        capture_enable, run_stop, comp_b_data_mode, comp_b_use_wdata, trigger_select_option;
    logic        break_req, break_tag, trigger_hit, ce, comp_b_rdata_hit, comp_b_wdata_hit;
    // Which comparator B raw input a B hit lands on: bit0 address, bit1 read data, bit2 write data
    logic [2:0]  b_sel;
    int          n_force, n_tag, n_long, num_errors, cmp_count, cycles, exp_force, exp_tag, stops, s0, hits, h0;
    // Register rows: written value, expected capture enable, expected active flag
    logic [9:0]  regs [6] = '{10'h200, 10'h303, 10'h1fd, 10'h000, 10'h2b0, 10'h155};
    // Trigger rows: control, A hit, B hit, read cycle, break expected
    logic [11:0] rows [10] = '{12'hd4a, 12'hd49, 12'hdcb, 12'hd16, 12'hd15, 12'hd37,
                               12'hf09, 12'hc08, 12'h908, 12'h508};

    dtc_top i_dtc_top (.mclk(mclk), .resetn(resetn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .secure_pin(secure_pin),
        .bus_valid(bus_valid), .bus_read(bus_read), .comp_a_hit(comp_a_hit), .comp_b_addr_hit(comp_b_addr_hit),
        .comp_b_rdata_hit(comp_b_rdata_hit), .comp_b_wdata_hit(comp_b_wdata_hit),
        .serial_debug_port_busy(serial_debug_port_busy),
        .fifo_full(fifo_full), .capture_enable(capture_enable), .run_stop(run_stop),
        .comp_b_data_mode(comp_b_data_mode), .comp_b_use_wdata(comp_b_use_wdata),
        .trigger_select_option(trigger_select_option), .break_req(break_req), .break_tag(break_tag),
        .trigger_hit(trigger_hit));

    dtc_cpu_model i_dtc_cpu_model (.mclk(mclk), .resetn(resetn), .break_req(break_req), .break_tag(break_tag),
        .n_force(n_force), .n_tag(n_tag), .n_long(n_long));

    // Clock generator
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Cycle ceiling and stop pulse tally; the ceiling sits well above the expected run
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (run_stop === 1'b1) stops <= stops + 1;
        if (trigger_hit === 1'b1) hits <= hits + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low at a falling edge, then through the next rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        // Waitrequest stands from the launching rising edge to the next rising edge; only the ceiling ends a hang
        do begin
            @(negedge mclk);
        end while (avs_waitrequest !== 1'b0);
        @(posedge mclk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // Outputs launched by the taking edge settle before any check looks at them
        @(negedge mclk);
    endtask

    // One-cycle CPU bus event, then a settle gap
    task automatic fire(input logic a, input logic b, input logic rd, input logic ff, input logic busy);
        @(posedge mclk);
        bus_valid              <= 1'b1;
        comp_a_hit             <= a;
        comp_b_addr_hit        <= b && b_sel[0];
        comp_b_rdata_hit       <= b && b_sel[1];
        comp_b_wdata_hit       <= b && b_sel[2];
        bus_read               <= rd;
        fifo_full              <= ff;
        serial_debug_port_busy <= busy;
        @(posedge mclk);
        bus_valid              <= 1'b0;
        comp_a_hit             <= 1'b0;
        comp_b_addr_hit        <= 1'b0;
        comp_b_rdata_hit       <= 1'b0;
        comp_b_wdata_hit       <= 1'b0;
        fifo_full              <= 1'b0;
        serial_debug_port_busy <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {avs_read, avs_write, secure_pin, bus_valid, bus_read, comp_a_hit, comp_b_addr_hit} = '0;
        {serial_debug_port_busy, fifo_full, avs_address, avs_byteenable, avs_writedata} = '0;
        {comp_b_rdata_hit, comp_b_wdata_hit} = '0;
        {num_errors, cmp_count, cycles, exp_force, exp_tag, stops, hits, h0} = '0;
        ce = 1'b1;
        b_sel = 3'b001;
        resetn = 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        bus(0, 4'h0, 32'h0, 4'hf);
        chk(q, 32'h0);
        chk(capture_enable, 1'b0);
        // Plain register rows, written and read back
        for (int i = 0; i < 6; i++) begin
            bus(1, 4'h0, {24'h0, regs[i][9:2]}, 4'hf);
            bus(0, 4'h0, 32'h0, 4'hf);
            chk(q, {24'h0, regs[i][9:2]});
            chk(capture_enable, regs[i][1]);
            bus(0, 4'h4, 32'h0, 4'hf);
            chk(q[0], regs[i][0]);
        end
        // Trigger rows in end trace
        bus(1, 4'h8, 32'h0, 4'hf);
        for (int i = 0; i < 10; i++) begin
            bus(1, 4'h0, {24'h0, rows[i][11:4]}, 4'hf);
            fire(rows[i][3], rows[i][2], rows[i][1], 1'b0, 1'b0);
            if (rows[i][0] && rows[i][9]) exp_tag++;
            if (rows[i][0] && !rows[i][9]) exp_force++;
            chk(n_force, exp_force);
            chk(n_tag, exp_tag);
            if (rows[i][0]) begin
                bus(0, 4'h0, 32'h0, 4'hf);
                chk(q, {24'h0, rows[i][11:4] & 8'hbf});
            end
        end
        // Begin trace, both trigger selections: break only on FIFO fill
        for (int s = 1; s < 4; s += 2) begin
            bus(1, 4'h8, s, 4'hf);
            chk(trigger_select_option, s[1]);
            bus(1, 4'h0, 32'hd0, 4'hf);
            h0 = hits;
            fire(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            chk(n_force, exp_force);
            chk(hits - h0, 1);
            fire(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
            exp_force++;
            chk(n_force, exp_force);
        end
        // Comparators blind while the serial port is busy
        bus(1, 4'h8, 32'h0, 4'hf);
        bus(1, 4'h0, 32'hd0, 4'hf);
        fire(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        chk(n_force, exp_force);
        // Clearing enable mid-run stops it
        s0 = stops;
        bus(1, 4'h0, 32'h40, 4'hf);
        repeat (2) @(posedge mclk);
        chk(stops - s0, 1);
        chk(capture_enable, 1'b0);
        // Secure state refuses to raise the enable
        bus(1, 4'h0, 32'h0, 4'hf);
        secure_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1, 4'h0, 32'h80, 4'hf);
        bus(0, 4'h0, 32'h0, 4'hf);
        chk(q, 32'h0);
        secure_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        bus(1, 4'h0, 32'h80, 4'hf);
        bus(0, 4'h0, 32'h0, 4'hf);
        chk(q, 32'h80);
        // Data-mode bus choice for comparator B
        bus(1, 4'h8, 32'h4, 4'hf);
        chk(comp_b_data_mode, 1'b1);
        bus(1, 4'h0, 32'h04, 4'hf);
        chk(comp_b_use_wdata, 1'b1);
        // Write data bus chosen: a read data hit alone must not trigger
        bus(1, 4'h0, 32'hd4, 4'hf);
        b_sel = 3'b010;
        fire(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        chk(n_force, exp_force);
        b_sel = 3'b100;
        fire(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        exp_force++;
        chk(n_force, exp_force);
        b_sel = 3'b001;
        bus(1, 4'h0, 32'h0c, 4'hf);
        chk(comp_b_use_wdata, 1'b0);
        // Dropped write lane and unmapped read
        bus(1, 4'h0, 32'hff, 4'he);
        bus(0, 4'h0, 32'h0, 4'hf);
        chk(q, 32'h0c);
        bus(0, 4'hc, 32'h0, 4'hf);
        chk(q, 32'h0);
        // Clock enable low freezes everything: a trigger then neither breaks nor ends the run
        bus(1, 4'h0, 32'hd0, 4'hf);
        @(posedge mclk);
        ce <= 1'b0;
        fire(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(n_force, exp_force);
        @(posedge mclk);
        ce <= 1'b1;
        bus(0, 4'h0, 32'h0, 4'hf);
        chk(q, 32'hd0);
        chk(n_long, 0);
        complete_run();
    end
endmodule
